// ==== pkg/rcq_pkg.sv ====
`default_nettype none
package rcq_pkg;

    // Memory layout: clock registers first, general bytes after them.
    localparam int unsigned RCQ_CLK_REGS = 14;
    localparam int unsigned RCQ_GP_BYTES = 114;
    localparam int unsigned RCQ_MEM_BYTES = RCQ_CLK_REGS + RCQ_GP_BYTES;
    localparam int unsigned RCQ_AW = 7;

    // Offset of status register C inside the clock register bank.
    localparam logic [6:0] RCQ_REG_C = 7'h0c;

    // Value written into cleared general-purpose bytes.
    localparam logic [7:0] RCQ_CLEAR_VAL = 8'h00;

    // Time base frequency in hertz and its one-second divider width.
    localparam int unsigned RCQ_TB_HZ = 32768;
    localparam int unsigned RCQ_TB_W = $clog2(RCQ_TB_HZ);

    // Memory access request carried between host side and the store.
    typedef struct packed {
        logic req;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rcq_mem_req_t;

endpackage
`default_nettype wire

// ==== rtl/rcq_rtc.sv ====
`timescale 1ns/100ps
`default_nettype none
// Clock memory with hardware RAM clear and interrupt request pin.
module rcq_rtc
    import rcq_pkg::*;
#(
    parameter int unsigned TB_DIV = RCQ_TB_HZ
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic time_base_crystal,
    input wire logic ram_clear_n,
    input wire rcq_mem_req_t mem_req,
    input wire logic irq_event,
    output logic [7:0] mem_rdata,
    output logic clear_busy,
    output logic sec_tick,
    output logic clock_interrupt_request_n_o,
    output logic clock_interrupt_request_n_oe
);

    // Two-stage synchronisers for the time base and the clear pin.
    logic [1:0] tb_sync_q, tb_sync_d;
    logic [1:0] clr_sync_q, clr_sync_d;
    logic tb_prev_q, tb_prev_d;
    logic clr_prev_q, clr_prev_d;

    // Clear walker: index over the general bytes and a busy flag.
    logic [RCQ_AW-1:0] clr_idx_q, clr_idx_d;
    logic busy_q, busy_d;

    // Interrupt pending latch and registered outputs.
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;

    // Byte storage held in flip-flops.
    logic [7:0] mem_q [RCQ_MEM_BYTES];
    logic [7:0] mem_d [RCQ_MEM_BYTES];

    logic tb_edge;
    logic sec_pulse;
    logic clr_fall;
    logic rd_c;

    // Rising time base edge, read from the second sync stage only.
    assign tb_edge = tb_sync_q[1] & ~tb_prev_q;
    // Clear starts on a falling edge of the synchronised pin.
    assign clr_fall = ~clr_sync_q[1] & clr_prev_q;
    // A read of status register C acknowledges the interrupt.
    assign rd_c = mem_req.req & ~mem_req.wr & (mem_req.addr == RCQ_REG_C);

    // The one-second divider runs on every time base edge regardless
    // of any clear, so no time is lost.
    rcq_tick #(
        .DIV(TB_DIV)
    ) u_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tb_edge(tb_edge),
        .sec_pulse(sec_pulse)
    );

    // Synchroniser next values; pins pass two flops before any use.
    always_comb begin
        tb_sync_d = {tb_sync_q[0], time_base_crystal};
        clr_sync_d = {clr_sync_q[0], ram_clear_n};
        tb_prev_d = tb_sync_q[1];
        clr_prev_d = clr_sync_q[1];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tb_sync_q <= 2'h0;
            clr_sync_q <= 2'h3;
            tb_prev_q <= 1'b0;
            clr_prev_q <= 1'b1;
        end else begin
            tb_sync_q <= tb_sync_d;
            clr_sync_q <= clr_sync_d;
            tb_prev_q <= tb_prev_d;
            clr_prev_q <= clr_prev_d;
        end
    end

    // Memory next values. The clear erases one general byte per cycle
    // so the host port keeps working; a host write wins on its byte.
    // Writing one byte a cycle costs 114 cycles but avoids a wide
    // single-cycle wipe that would block host access.
    always_comb begin
        for (int i = 0; i < RCQ_MEM_BYTES; i++) begin
            mem_d[i] = mem_q[i];
        end
        clr_idx_d = clr_idx_q;
        busy_d = busy_q;
        rdata_d = rdata_q;
        if (busy_q) begin
            // Only indices at or above the clock bank are touched.
            mem_d[RCQ_CLK_REGS + 32'(clr_idx_q)] = RCQ_CLEAR_VAL;
            if (clr_idx_q == RCQ_AW'(RCQ_GP_BYTES - 1)) begin
                busy_d = 1'b0;
                clr_idx_d = '0;
            end else begin
                clr_idx_d = clr_idx_q + 1'b1;
            end
        end else if (clr_fall) begin
            busy_d = 1'b1;
            clr_idx_d = '0;
        end
        if (mem_req.req && 32'(mem_req.addr) < RCQ_MEM_BYTES) begin
            if (mem_req.wr) begin
                mem_d[mem_req.addr] = mem_req.wdata;
            end else begin
                rdata_d = mem_q[mem_req.addr];
            end
        end else if (mem_req.req && !mem_req.wr) begin
            // Addresses past the store read as zero.
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < RCQ_MEM_BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
            clr_idx_q <= '0;
            busy_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            for (int i = 0; i < RCQ_MEM_BYTES; i++) begin
                mem_q[i] <= mem_d[i];
            end
            clr_idx_q <= clr_idx_d;
            busy_q <= busy_d;
            rdata_q <= rdata_d;
        end
    end

    // Interrupt pending: a new event wins over a same-cycle C read.
    always_comb begin
        irq_d = irq_q;
        if (rd_c) begin
            irq_d = 1'b0;
        end
        if (irq_event) begin
            irq_d = 1'b1;
        end
    end

    // Reset releases the pin as well as clearing the pending flag.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // The pin only ever drives low; otherwise it is released.
    assign clock_interrupt_request_n_o = 1'b0;
    assign clock_interrupt_request_n_oe = irq_q;
    assign mem_rdata = rdata_q;
    assign clear_busy = busy_q;
    assign sec_tick = sec_pulse;

    // Cover the main scenarios.
    COV_CLEAR: cover property (@(posedge clk_sys) disable iff (sys_rst)
        clr_fall ##1 busy_q);
    COV_IRQ: cover property (@(posedge clk_sys) disable iff (sys_rst)
        irq_q ##1 rd_c ##1 !irq_q);
    COV_SEC: cover property (@(posedge clk_sys) disable iff (sys_rst)
        sec_pulse);
    // A host write to a clock register while the walker is busy.
    COV_ACCESS: cover property (@(posedge clk_sys) disable iff (sys_rst)
        busy_q && mem_req.req && mem_req.wr && mem_req.addr < 7'h0e);

    AST_CLR_START: assert property (@(posedge clk_sys)
        disable iff (sys_rst) (clr_fall && !busy_q) |=> busy_q)
        else $error("clear did not start");
    AST_CLR_LEN: assert property (@(posedge clk_sys)
        disable iff (sys_rst) $rose(busy_q) |-> busy_q [*8])
        else $error("clear ended early");
    AST_CLR_ZERO: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (busy_q && !mem_req.req) |=>
        mem_q[RCQ_CLK_REGS + 32'($past(clr_idx_q))] == RCQ_CLEAR_VAL)
        else $error("general byte not cleared");
    AST_CLK_KEEP: assert property (@(posedge clk_sys)
        disable iff (sys_rst) (busy_q && !mem_req.req) |=>
        mem_q[RCQ_REG_C] == $past(mem_q[RCQ_REG_C]))
        else $error("clock register changed by clear");
    AST_ACCESS: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (busy_q && mem_req.req && mem_req.wr && mem_req.addr < 7'h0e)
        |=> mem_q[$past(mem_req.addr)] == $past(mem_req.wdata))
        else $error("host write lost during clear");
    // With no pending request and no new event the pin stays released.
    AST_FLOAT: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (!clock_interrupt_request_n_oe && !irq_event) |=>
        !clock_interrupt_request_n_oe)
        else $error("pin driven with nothing pending");
    AST_HOLD: assert property (@(posedge clk_sys)
        disable iff (sys_rst) (irq_q && !rd_c) |=> irq_q)
        else $error("request dropped before C read");
    AST_ACK: assert property (@(posedge clk_sys)
        disable iff (sys_rst) (rd_c && !irq_event) |=>
        !clock_interrupt_request_n_oe)
        else $error("C read did not release pin");
    AST_EVT: assert property (@(posedge clk_sys)
        disable iff (sys_rst) irq_event |=>
        clock_interrupt_request_n_oe && !clock_interrupt_request_n_o)
        else $error("event did not drive pin low");
    // The walker advances by one byte each busy cycle, none skipped.
    AST_CLR_STEP: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (busy_q && clr_idx_q != RCQ_AW'(RCQ_GP_BYTES - 1)) |=>
        (busy_q && clr_idx_q == $past(clr_idx_q) + 1'b1))
        else $error("clear walker skipped a byte");
    // The walk stops right after the last general byte.
    AST_CLR_END: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (busy_q && clr_idx_q == RCQ_AW'(RCQ_GP_BYTES - 1)) |=> !busy_q)
        else $error("clear did not stop after last byte");
    // A second pulse only ever follows a counted time base edge.
    AST_TICK: assert property (@(posedge clk_sys)
        disable iff (sys_rst) sec_pulse |-> $past(tb_edge))
        else $error("second pulse without a time base edge");

endmodule
`default_nettype wire

// ==== rtl/rcq_tick.sv ====
`timescale 1ns/100ps
`default_nettype none
// Counts synchronised time base edges and pulses once per second.
module rcq_tick
    import rcq_pkg::*;
#(
    parameter int unsigned DIV = RCQ_TB_HZ
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tb_edge,
    output logic sec_pulse
);

    // Divider counter, wide enough for the full time base rate.
    logic [RCQ_TB_W-1:0] cnt_q, cnt_d;
    logic sec_q, sec_d;

    // Next-state logic: wrap after DIV edges and flag the second.
    always_comb begin
        cnt_d = cnt_q;
        sec_d = 1'b0;
        if (tb_edge) begin
            if (cnt_q == RCQ_TB_W'(DIV - 1)) begin
                cnt_d = '0;
                sec_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            sec_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sec_q <= sec_d;
        end
    end

    assign sec_pulse = sec_q;

endmodule
`default_nettype wire

// ==== tb/rcq_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Host interrupt input with a pull-up on the shared request line.
module rcq_host (
    input wire logic clk_sys,
    input wire logic irq_o,
    input wire logic irq_oe,
    output logic irq_line_n,
    output logic irq_seen
);
    // The line only goes low when driven, so a stuck enable stays visible.
    assign irq_line_n = irq_oe ? irq_o : 1'b1;
    // The controller input stage samples the line once a cycle.
    always_ff @(posedge clk_sys) begin
        irq_seen <= ~irq_line_n;
    end
endmodule
`default_nettype wire

// ==== tb/tb_rtc_ram_clear_irq.sv ====
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for clear, time base and request pin.
module tb_rtc_ram_clear_irq;
    import rcq_pkg::*;
    localparam int unsigned DIV = 4; // Short divider keeps the run brief.
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic time_base_crystal = 1'b0;
    logic ram_clear_n = 1'b1;
    rcq_mem_req_t mem_req = '0;
    logic irq_event = 1'b0;
    logic [7:0] mem_rdata, rd_q;
    logic clear_busy, sec_tick, irq_o, irq_oe, irq_line_n, irq_seen;
    logic [7:0] exp_mem [RCQ_MEM_BYTES]; // Bench copy of the memory.
    int miscompares = 0;
    int tests_run = 0;
    int ticks = 0;

    rcq_rtc #(.TB_DIV(DIV)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .time_base_crystal(time_base_crystal), .ram_clear_n(ram_clear_n),
        .mem_req(mem_req), .irq_event(irq_event), .mem_rdata(mem_rdata),
        .clear_busy(clear_busy), .sec_tick(sec_tick),
        .clock_interrupt_request_n_o(irq_o),
        .clock_interrupt_request_n_oe(irq_oe));
    rcq_host host_u (.clk_sys(clk_sys), .irq_o(irq_o), .irq_oe(irq_oe),
        .irq_line_n(irq_line_n), .irq_seen(irq_seen));

    // Free-running system clock.
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // Count one-second pulses, sampled mid-cycle where they have settled.
    always @(negedge clk_sys) begin
        if (sec_tick === 1'b1) ticks <= ticks + 1;
    end
    // Expected byte after a clear: clock registers keep their value.
    function automatic logic [7:0] cleared(input int a);
        return (a < RCQ_CLK_REGS) ? exp_mem[a] : RCQ_CLEAR_VAL;
    endfunction
    // Inputs move a fixed delay after the rising edge.
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    // One-cycle memory request; read data is taken one edge later.
    task automatic mem(input logic wr, input logic [6:0] a,
                       input logic [7:0] d);
        step();
        mem_req = '{req: 1'b1, wr: wr, addr: a, wdata: d};
        step();
        mem_req = '{req: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        step();
        rd_q = mem_rdata;
    endtask
    // Compare and report at once.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    // Single place where the run ends.
    task automatic finish_test();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short well after the expected thousand or so cycles.
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h980455f6));
        repeat (12) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        for (int a = 0; a < RCQ_MEM_BYTES; a++) begin
            exp_mem[a] = 8'($urandom());
            mem(1'b1, 7'(a), exp_mem[a]);
        end
        exp_mem[127] = 8'hff; // Corner value in the last byte.
        mem(1'b1, 7'h7f, 8'hff);
        step();
        ram_clear_n = 1'b0;
        for (int i = 0; i < 10 && clear_busy !== 1'b1; i++) step();
        chk(clear_busy, 1'b1);
        // A host write to a clock register lands while the clear walks.
        exp_mem[5] = 8'($urandom());
        mem(1'b1, 7'h05, exp_mem[5]);
        // Time base keeps counting while the clear walks.
        repeat (16) begin
            repeat (5) @(posedge clk_sys);
            #1 time_base_crystal = ~time_base_crystal;
        end
        for (int a = 0; a < RCQ_CLK_REGS; a++) begin
            mem(1'b0, 7'(a), 8'h00);
            chk(rd_q, exp_mem[a]);
        end
        for (int i = 0; i < 200 && clear_busy !== 1'b0; i++) step();
        chk(clear_busy, 1'b0);
        ram_clear_n = 1'b1;
        repeat (4) step();
        chk(8'(ticks), 8'(8 / DIV));
        for (int a = 0; a < RCQ_MEM_BYTES; a++) begin
            mem(1'b0, 7'(a), 8'h00);
            chk(rd_q, cleared(a));
        end
        chk(irq_line_n, 1'b1);
        step();
        irq_event = 1'b1;
        step();
        irq_event = 1'b0;
        step();
        chk(irq_line_n, 1'b0);
        chk(irq_seen, 1'b1);
        mem(1'b0, 7'h0b, 8'h00);
        chk(irq_line_n, 1'b0);
        mem(1'b0, RCQ_REG_C, 8'h00);
        step();
        chk(irq_line_n, 1'b1);
        irq_event = 1'b1;
        step();
        irq_event = 1'b0;
        step();
        chk(irq_line_n, 1'b0);
        sys_rst = 1'b1;
        repeat (2) step();
        chk(irq_line_n, 1'b1);
        sys_rst = 1'b0;
        step();
        chk(irq_line_n, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
